/* hdl/dpi_defs.svh */
// Constants of the pixel input port: bus layout, reset values, rates.
// Assumes inclusion by bare name from the package and design files.
`ifndef DPI_DEFS_SVH
`define DPI_DEFS_SVH

// Pixel bus layout
`define DPI_PIX_W        24
`define DPI_HALF_W       12
`define DPI_UPPER_MSB    23
`define DPI_UPPER_LSB    12
`define DPI_LOWER_MSB    11
`define DPI_LOWER_LSB    0
`define DPI_SNAP_MSB     23
`define DPI_SNAP_LSB     16
`define DPI_SNAP_W       8
`define DPI_AUX_W        3

// Reset values
`define DPI_SNAP_RST     8'h00
`define DPI_PIX_RST      24'h000000
`define DPI_AUX_RST      3'h0

// Rates in MHz
`define DPI_REF_CLK_MHZ  125
`define DPI_PIX_MIN_MHZ  25
`define DPI_PIX_MAX_MHZ  165

// Buffer
`define DPI_BUF_DEPTH    2

// Edges before the pin synchronisers show real pin levels
`define DPI_SYNC_DEPTH   2'h2

`endif

/* hdl/dpi_pixel_input.sv */
// Pixel input port: samples the controller's source-synchronous bus and
// turns it into a stream of pixel or blanking-control words.
// Assumes all pin inputs are asynchronous to ref_clk and that the
// pixel input clock is well below half the ref_clk rate.
//
// What this block does
// - Wide mode: pixel upper half comes from input bits 23..12.
// - Wide mode: lower half from bits 11..0, one pixel per rising edge.
// - Narrow mode: a 12-bit half pixel captured on every clock edge.
// - Narrow mode: bits 23..12 never enter the pixel stream.
// - Narrow mode: bits 23..16 copied into the 8-bit configuration snapshot.
// - Active video high: the 24-bit word is passed on as pixel data.
// - Active video low: syncs and three auxiliary bits passed instead.
// - Pixel clock rates from 25 MHz up to well below half the 125 MHz ref_clk are accepted.
// - Serial host off: width select pin is the strap, high means wide.
// - Bus, qualifier and syncs are latched against the pixel clock.
`timescale 1ns/1ps
`include "dpi_defs.svh"

module dpi_pixel_input (
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    reset_n,
  // Controller pins
  input  wire logic                    pixelInputClock,
  input  wire logic [`DPI_PIX_W-1:0]   pixelData,
  input  wire logic                    activeVideoFlag,
  input  wire logic                    hsyncIn,
  input  wire logic                    vsyncIn,
  input  wire logic [`DPI_AUX_W-1:0]   auxControlBits,
  // Configuration pins and serial host mode
  input  wire logic                    busWidthSelect,
  input  wire logic                    serialHostSelect,
  input  wire logic                    hostWideMode,
  // Snapshot read by the serial host
  output logic [`DPI_SNAP_W-1:0]       pinConfigSnapshot,
  // Word stream to the encoder
  output logic                         wordValid,
  input  wire logic                    wordReady,
  output dpi_pkg::dpi_word_t           wordOut,
  // Status
  output logic                         overrun,
  output dpi_pkg::dpi_mode_t           activeMode
);
  import dpi_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Join a pixel or a control word
  function automatic dpi_word_t makeWord(input logic video,
                                         input logic [`DPI_PIX_W-1:0] pix,
                                         input logic hs,
                                         input logic vs,
                                         input logic [`DPI_AUX_W-1:0] aux);
    dpi_word_t w;
    w.video = video;
    w.pixel = video ? pix : `DPI_PIX_RST;
    w.hsync = video ? 1'b0 : hs;
    w.vsync = video ? 1'b0 : vs;
    w.aux   = video ? `DPI_AUX_RST : aux;
    return w;
  endfunction : makeWord

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: two flops, the second alone is read
  localparam int SYNC_W = `DPI_PIX_W + `DPI_AUX_W + 6;
  logic [SYNC_W-1:0] syncA_q, syncB_q;
  logic [SYNC_W-1:0] pinBus;
  logic              clkPrev_q;

  assign pinBus = {pixelInputClock, pixelData, activeVideoFlag, hsyncIn,
                   vsyncIn, auxControlBits, busWidthSelect, serialHostSelect};

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      syncA_q   <= '0;
      syncB_q   <= '0;
      clkPrev_q <= 1'b0;
    end else begin
      syncA_q   <= pinBus;
      syncB_q   <= syncA_q;
      clkPrev_q <= syncB_q[SYNC_W-1];
    end
  end

  logic                   sClk;
  logic [`DPI_PIX_W-1:0]  sData;
  logic                   sVideo, sHs, sVs, sBsel, sIsel;
  logic [`DPI_AUX_W-1:0]  sAux;
  logic                   riseEdge, fallEdge;

  assign {sClk, sData, sVideo, sHs, sVs, sAux, sBsel, sIsel} = syncB_q;
  assign riseEdge = sClk && !clkPrev_q;
  assign fallEdge = !sClk && clkPrev_q;

  //////////////////////////////////////////////////////////////////////////
  // Mode selection; strap caught once after reset
  logic       strapDone_q, strapDone_d;
  logic [1:0] strapAge_q, strapAge_d;
  dpi_mode_t  strap_q, strap_d;

  always_comb begin
    strapDone_d = strapDone_q;
    strapAge_d  = strapAge_q;
    strap_d     = strap_q;
    // Synchronisers hold their reset value until two edges have passed
    if (strapAge_q != `DPI_SYNC_DEPTH) begin
      strapAge_d = strapAge_q + 2'h1;
    end else if (!strapDone_q) begin
      strap_d     = sBsel ? DPI_WIDE_SINGLE : DPI_NARROW_DUAL;
      strapDone_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      strapDone_q <= 1'b0;
      strapAge_q  <= 2'h0;
      strap_q     <= DPI_WIDE_SINGLE;
    end else begin
      strapDone_q <= strapDone_d;
      strapAge_q  <= strapAge_d;
      strap_q     <= strap_d;
    end
  end

  assign activeMode = sIsel ? (hostWideMode ? DPI_WIDE_SINGLE : DPI_NARROW_DUAL)
                            : strap_q;

  //////////////////////////////////////////////////////////////////////////
  // Capture
  logic [`DPI_HALF_W-1:0] lowHalf_q, lowHalf_d;
  logic                   haveLow_q, haveLow_d;
  logic                   capVideo_q, capVideo_d;
  logic                   capHs_q, capHs_d;
  logic                   capVs_q, capVs_d;
  logic [`DPI_AUX_W-1:0]  capAux_q, capAux_d;
  logic [`DPI_SNAP_W-1:0] snap_q, snap_d;
  dpi_word_t              word_q, word_d;
  logic                   wordVld_q, wordVld_d;
  logic                   overrun_q, overrun_d;
  logic                   bufReady;

  always_comb begin
    lowHalf_d  = lowHalf_q;
    haveLow_d  = haveLow_q;
    capVideo_d = capVideo_q;
    capHs_d    = capHs_q;
    capVs_d    = capVs_q;
    capAux_d   = capAux_q;
    snap_d     = snap_q;
    word_d     = word_q;
    wordVld_d  = wordVld_q && !bufReady;
    // Input cannot stall, so a word with no room is dropped and flagged
    overrun_d  = overrun_q;
    if (activeMode == DPI_WIDE_SINGLE) begin
      haveLow_d = 1'b0;
      if (riseEdge) begin
        word_d    = makeWord(sVideo,
                             {sData[`DPI_UPPER_MSB:`DPI_UPPER_LSB],
                              sData[`DPI_LOWER_MSB:`DPI_LOWER_LSB]},
                             sHs, sVs, sAux);
        wordVld_d = 1'b1;
        overrun_d = overrun_q || (wordVld_q && !bufReady);
      end
    end else begin
      if (riseEdge) begin
        lowHalf_d  = sData[`DPI_LOWER_MSB:`DPI_LOWER_LSB];
        haveLow_d  = 1'b1;
        capVideo_d = sVideo;
        capHs_d    = sHs;
        capVs_d    = sVs;
        capAux_d   = sAux;
        snap_d     = sData[`DPI_SNAP_MSB:`DPI_SNAP_LSB];
      end else if (fallEdge && haveLow_q) begin
        word_d    = makeWord(capVideo_q,
                             {sData[`DPI_LOWER_MSB:`DPI_LOWER_LSB], lowHalf_q},
                             capHs_q, capVs_q, capAux_q);
        wordVld_d = 1'b1;
        haveLow_d = 1'b0;
        overrun_d = overrun_q || (wordVld_q && !bufReady);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      lowHalf_q  <= '0;
      haveLow_q  <= 1'b0;
      capVideo_q <= 1'b0;
      capHs_q    <= 1'b0;
      capVs_q    <= 1'b0;
      capAux_q   <= `DPI_AUX_RST;
      snap_q     <= `DPI_SNAP_RST;
      word_q     <= '0;
      wordVld_q  <= 1'b0;
      overrun_q  <= 1'b0;
    end else begin
      lowHalf_q  <= lowHalf_d;
      haveLow_q  <= haveLow_d;
      capVideo_q <= capVideo_d;
      capHs_q    <= capHs_d;
      capVs_q    <= capVs_d;
      capAux_q   <= capAux_d;
      snap_q     <= snap_d;
      word_q     <= word_d;
      wordVld_q  <= wordVld_d;
      overrun_q  <= overrun_d;
    end
  end

  assign pinConfigSnapshot = snap_q;
  assign overrun           = overrun_q;

  //////////////////////////////////////////////////////////////////////////
  // Output buffer absorbs short encoder stalls
  dpi_word_buf u_buf (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .inValid  (wordVld_q),
    .inReady  (bufReady),
    .inWord   (word_q),
    .outValid (wordValid),
    .outReady (wordReady),
    .outWord  (wordOut)
  );

endmodule : dpi_pixel_input

/* hdl/dpi_pkg.sv */
// Types shared by the pixel input port and its output buffer.
// Assumes dpi_defs.svh is on the include path.
`include "dpi_defs.svh"

package dpi_pkg;

  // One captured input cycle, pixel or blanking control
  typedef struct packed {
    logic                   video;
    logic [`DPI_PIX_W-1:0]  pixel;
    logic                   hsync;
    logic                   vsync;
    logic [`DPI_AUX_W-1:0]  aux;
  } dpi_word_t;

  // Input bus mode
  typedef enum logic {
    DPI_NARROW_DUAL,
    DPI_WIDE_SINGLE
  } dpi_mode_t;

endpackage : dpi_pkg

/* hdl/dpi_word_buf.sv */
// Two-entry word buffer with valid/ready on both sides.
// Assumes producer and consumer share ref_clk.
`timescale 1ns/1ps
`include "dpi_defs.svh"

module dpi_word_buf (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  // Fill side
  input  wire logic              inValid,
  output logic                   inReady,
  input  wire dpi_pkg::dpi_word_t inWord,
  // Drain side
  output logic                   outValid,
  input  wire logic              outReady,
  output dpi_pkg::dpi_word_t     outWord
);
  import dpi_pkg::*;

  dpi_word_t  mem_q [`DPI_BUF_DEPTH];
  dpi_word_t  mem_d [`DPI_BUF_DEPTH];
  logic       wrPtr_q, wrPtr_d;
  logic       rdPtr_q, rdPtr_d;
  logic [1:0] count_q, count_d;
  logic       push;
  logic       pop;

  assign inReady  = (count_q != 2'(`DPI_BUF_DEPTH));
  assign outValid = (count_q != 2'h0);
  assign outWord  = mem_q[rdPtr_q];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_comb begin
    mem_d   = mem_q;
    wrPtr_d = wrPtr_q;
    rdPtr_d = rdPtr_q;
    count_d = count_q;
    if (push) begin
      mem_d[wrPtr_q] = inWord;
      wrPtr_d        = ~wrPtr_q;
    end
    if (pop) begin
      rdPtr_d = ~rdPtr_q;
    end
    if (push && !pop) begin
      count_d = count_q + 2'h1;
    end else if (pop && !push) begin
      count_d = count_q - 2'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      wrPtr_q  <= 1'b0;
      rdPtr_q  <= 1'b0;
      count_q  <= 2'h0;
    end else begin
      mem_q    <= mem_d;
      wrPtr_q  <= wrPtr_d;
      rdPtr_q  <= rdPtr_d;
      count_q  <= count_d;
    end
  end

endmodule : dpi_word_buf

/* test/dpi_ctrl_model.sv */
// Graphics controller model driving the pixel bus and its clock.
// Assumes ref_clk for pacing; pixel clock 168 ns, still between pixels.
`timescale 1ns/1ps
module dpi_ctrl_model (
  // Pacing clock
  input  logic        ref_clk,
  // Pixel pins
  output logic        pixClk,
  output logic [23:0] pixData,
  output logic        video,
  output logic [4:0]  ctl
);
  initial begin
    pixClk = 1'b0;
    pixData = 24'h000000;
    video = 1'b0;
    ctl = 5'h00;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : hold
  task automatic send(input logic wide, input logic de, input logic [23:0] pix, input logic [7:0] cfg,
                      input logic [4:0] c);
    @(negedge ref_clk);
    video = de;
    ctl = c;
    pixData = wide ? pix : {cfg, ~pix[23:20], pix[11:0]};
    hold(5);
    pixClk = 1'b1;
    hold(5);
    pixData = wide ? ~pix : {cfg, ~pix[23:20], pix[23:12]};
    hold(5);
    pixClk = 1'b0;
    hold(5);
    // Released lines show the inverse, not a stale value
    pixData = ~pixData;
    ctl = ~ctl;
  endtask : send
endmodule : dpi_ctrl_model

/* test/dpi_pixel_input_props.sv */
// Checker for the pixel input port, bound to its top module.
// Assumes dpi_defs.svh on the include path and a single ref_clk domain.
`timescale 1ns/1ps
`include "dpi_defs.svh"
module dpi_pixel_input_props (
  // Clock and reset
  input logic                     ref_clk,
  input logic                     reset_n,
  // Pins
  input logic                     pixelInputClock,
  input logic [`DPI_PIX_W-1:0]    pixelData,
  input logic                     serialHostSelect,
  input logic                     hostWideMode,
  // Outputs and stream
  input logic [`DPI_SNAP_W-1:0]   pinConfigSnapshot,
  input logic                     wordValid,
  input logic                     wordReady,
  input dpi_pkg::dpi_word_t       wordOut,
  input dpi_pkg::dpi_mode_t       activeMode
);
  import dpi_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic [7:0] cfgPins;
  assign cfgPins = pixelData[23:16];
  ////////////////////////////////////////////////////////////////////////
  property p_vid_clean;
    wordValid && wordOut.video |-> {wordOut.hsync, wordOut.vsync, wordOut.aux} == 5'h00;
  endproperty
  a_vid_clean: assert property (p_vid_clean) else $error("control bits in video word");
  property p_blank_clean;
    wordValid && !wordOut.video |-> wordOut.pixel == 24'h000000;
  endproperty
  a_blank_clean: assert property (p_blank_clean) else $error("pixel in blanking word");
  property p_host_mode;
    serialHostSelect [*4] |-> activeMode == (hostWideMode ? DPI_WIDE_SINGLE : DPI_NARROW_DUAL);
  endproperty
  a_host_mode: assert property (p_host_mode) else $error("mode not from host");
  property p_snap_src;
    !$stable(pinConfigSnapshot) |-> activeMode == DPI_NARROW_DUAL && pinConfigSnapshot == $past(cfgPins, 3);
  endproperty
  a_snap_src: assert property (p_snap_src) else $error("snapshot source wrong");
  property p_snap_hold;
    activeMode == DPI_WIDE_SINGLE [*3] |=> $stable(pinConfigSnapshot);
  endproperty
  a_snap_hold: assert property (p_snap_hold) else $error("snapshot moved in wide mode");
  property p_wide_word;
    $rose(pixelInputClock) && activeMode == DPI_WIDE_SINGLE && wordReady |-> ##[2:8] wordValid;
  endproperty
  a_wide_word: assert property (p_wide_word) else $error("no word after wide edge");
  property p_narrow_pair;
    $rose(pixelInputClock) && activeMode == DPI_NARROW_DUAL && !wordValid |=> !wordValid [*6];
  endproperty
  a_narrow_pair: assert property (p_narrow_pair) else $error("word from half pixel");
  property p_word_stands;
    wordValid && !wordReady |=> wordValid && $stable(wordOut);
  endproperty
  a_word_stands: assert property (p_word_stands) else $error("word dropped in stall");
endmodule : dpi_pixel_input_props
bind dpi_pixel_input dpi_pixel_input_props u_props (.ref_clk(ref_clk), .reset_n(reset_n),
  .pixelInputClock(pixelInputClock), .pixelData(pixelData), .serialHostSelect(serialHostSelect),
  .hostWideMode(hostWideMode), .pinConfigSnapshot(pinConfigSnapshot), .wordValid(wordValid),
  .wordReady(wordReady), .wordOut(wordOut), .activeMode(activeMode));

/* test/dpi_pixel_input_test.sv */
// Testbench of the pixel input port with a controller model.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
`include "dpi_defs.svh"
module dpi_pixel_input_test;
  import dpi_pkg::*;
  logic ref_clk, reset_n, pixClk, video, busWidthSelect, serialHostSelect, hostWideMode, wordReady;
  logic wordValid, overrun;
  logic [23:0] pixData;
  logic [4:0] ctl;
  logic [7:0] snap;
  dpi_word_t wordOut;
  dpi_mode_t activeMode;
  dpi_word_t got[$];
  int n_fail, check_count;
  dpi_ctrl_model u_ctrl (.ref_clk(ref_clk), .pixClk(pixClk), .pixData(pixData), .video(video), .ctl(ctl));
  dpi_pixel_input uut (.ref_clk(ref_clk), .reset_n(reset_n), .pixelInputClock(pixClk),
    .pixelData(pixData), .activeVideoFlag(video), .hsyncIn(ctl[4]), .vsyncIn(ctl[3]),
    .auxControlBits(ctl[2:0]), .busWidthSelect(busWidthSelect), .serialHostSelect(serialHostSelect),
    .hostWideMode(hostWideMode), .pinConfigSnapshot(snap), .wordValid(wordValid), .wordReady(wordReady),
    .wordOut(wordOut), .overrun(overrun), .activeMode(activeMode));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (wordValid === 1'b1 && wordReady === 1'b1) got.push_back(wordOut);
  ////////////////////////////////////////////////////////////////////////
  task automatic bad(input string m);
    n_fail++;
    $display("wrong value at %0t: %s", $time, m);
  endtask : bad
  task automatic chk_word(input dpi_word_t e);
    dpi_word_t g;
    for (int i = 0; i < 300 && got.size() == 0; i++) @(posedge ref_clk);
    check_count++;
    if (got.size() == 0) bad("no word");
    else begin
      g = got.pop_front();
      if (g !== e) bad($sformatf("word %h exp %h", g, e));
    end
  endtask : chk_word
  task automatic chk_bits(input logic [7:0] g, input logic [7:0] e, input string m);
    check_count++;
    if (g !== e) bad($sformatf("%s %h exp %h", m, g, e));
  endtask : chk_bits
  task automatic end_of_test;
    $display("errors %0d checks %0d", n_fail, check_count);
    if (n_fail == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////
  task automatic t_narrow;
    chk_bits({7'h00, activeMode}, 8'h00, "strap mode");
    u_ctrl.send(1'b0, 1'b1, 24'h5a3c96, 8'ha5, 5'h1f);
    chk_word({1'b1, 24'h5a3c96, 5'h00});
    chk_bits(snap, 8'ha5, "snapshot");
    u_ctrl.send(1'b0, 1'b1, 24'hc3e1f0, 8'h3c, 5'h00);
    chk_word({1'b1, 24'hc3e1f0, 5'h00});
    chk_bits(snap, 8'h3c, "snapshot");
  endtask : t_narrow
  task automatic t_blank;
    u_ctrl.send(1'b0, 1'b0, 24'hffffff, 8'h3c, 5'h15);
    chk_word({1'b0, 24'h000000, 5'h15});
  endtask : t_blank
  task automatic t_wide;
    @(negedge ref_clk);
    serialHostSelect = 1'b1;
    hostWideMode = 1'b1;
    repeat (6) @(negedge ref_clk);
    chk_bits({7'h00, activeMode}, 8'h01, "host mode");
    u_ctrl.send(1'b1, 1'b1, 24'h9abcde, 8'h00, 5'h0a);
    chk_word({1'b1, 24'h9abcde, 5'h00});
    u_ctrl.send(1'b1, 1'b0, 24'h123456, 8'h00, 5'h0a);
    chk_word({1'b0, 24'h000000, 5'h0a});
    chk_bits(snap, 8'h3c, "snapshot held");
  endtask : t_wide
  task automatic t_stall;
    @(negedge ref_clk);
    wordReady = 1'b0;
    u_ctrl.send(1'b1, 1'b1, 24'h111111, 8'h00, 5'h00);
    u_ctrl.send(1'b1, 1'b1, 24'h222222, 8'h00, 5'h00);
    u_ctrl.send(1'b1, 1'b1, 24'h333333, 8'h00, 5'h00);
    chk_bits(8'(got.size()), 8'h00, "taken in stall");
    wordReady = 1'b1;
    chk_word({1'b1, 24'h111111, 5'h00});
    chk_word({1'b1, 24'h222222, 5'h00});
    chk_word({1'b1, 24'h333333, 5'h00});
    chk_bits({7'h00, overrun}, 8'h00, "overrun");
  endtask : t_stall
  task automatic t_overrun;
    @(negedge ref_clk);
    wordReady = 1'b0;
    u_ctrl.send(1'b1, 1'b1, 24'h444444, 8'h00, 5'h00);
    u_ctrl.send(1'b1, 1'b1, 24'h555555, 8'h00, 5'h00);
    u_ctrl.send(1'b1, 1'b1, 24'h666666, 8'h00, 5'h00);
    u_ctrl.send(1'b1, 1'b1, 24'h777777, 8'h00, 5'h00);
    chk_bits({7'h00, overrun}, 8'h01, "overrun set");
    wordReady = 1'b1;
    chk_word({1'b1, 24'h444444, 5'h00});
    chk_word({1'b1, 24'h555555, 5'h00});
    chk_word({1'b1, 24'h777777, 5'h00});
  endtask : t_overrun
  task automatic t_strap;
    @(negedge ref_clk);
    serialHostSelect = 1'b0;
    busWidthSelect = 1'b1;
    reset_n = 1'b0;
    repeat (8) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk_bits({7'h00, overrun}, 8'h00, "overrun after reset");
    chk_bits(snap, 8'h00, "snapshot after reset");
    chk_bits({7'h00, activeMode}, 8'h01, "wide strap");
    u_ctrl.send(1'b1, 1'b1, 24'h8e4d2b, 8'h00, 5'h00);
    chk_word({1'b1, 24'h8e4d2b, 5'h00});
  endtask : t_strap
  ////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'b0;
    busWidthSelect = 1'b0;
    serialHostSelect = 1'b0;
    hostWideMode = 1'b0;
    wordReady = 1'b1;
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    t_narrow();
    t_blank();
    t_wide();
    t_stall();
    t_overrun();
    t_strap();
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    end_of_test();
  end
endmodule : dpi_pixel_input_test
